// File: verilog/astc_pkg.sv
// Package: register map, field layout and timing constants for the start trigger block
`default_nettype none
package astc_pkg;

  // Register byte addresses (word aligned)
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_EXPOSURE = 4'h4;
  localparam logic [3:0] ADDR_COMMAND  = 4'h8;
  localparam logic [3:0] ADDR_STATUS   = 4'hc;

  // Control field positions
  localparam int CTRL_MODE_ON    = 0;
  localparam int CTRL_SRC_SW     = 1;
  localparam int CTRL_LINE_SEL   = 2;
  localparam int CTRL_FALLING    = 3;
  localparam int CTRL_WIDTH_MODE = 4;
  localparam int CTRL_SEL_START  = 5;
  localparam int CTRL_RATE_EN    = 6;
  localparam logic [6:0] CTRL_RESET = 7'h21;

  // Command bits (write one to fire)
  localparam int CMD_FIRE   = 0;
  localparam int CMD_ARM    = 1;
  localparam int CMD_DISARM = 2;
  localparam int CMD_OVR_CLR = 3;

  // Status bit positions
  localparam int ST_WAITING  = 0;
  localparam int ST_EXPOSING = 1;
  localparam int ST_READOUT  = 2;
  localparam int ST_ARMED    = 3;
  localparam int ST_OVERTRIG = 4;
  localparam int ST_FRAMES   = 8;

  localparam logic [23:0] EXPOSURE_RESET = 24'h000bb8;

  // Timing: microsecond tick from the 200 MHz clock
  localparam int CLK_MHZ       = 200;
  localparam int TICK_US       = 1;
  localparam int TICK_CYCLES   = CLK_MHZ * TICK_US;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

  // Readout length of a frame in microsecond ticks
  // Kept short so a full readout fits in a bench run
  localparam logic [23:0] READOUT_US = 24'h000064;

  typedef enum logic [3:0]
  {
    ST_IDLE_S = 4'h1,
    ST_WAIT_S = 4'h2,
    ST_EXP_S  = 4'h4,
    ST_HOLD_S = 4'h8
  } astc_state_t;

  typedef struct packed
  {
    logic       rate_en;
    logic       sel_start;
    logic       width_mode;
    logic       falling;
    logic       line_sel;
    logic       src_sw;
    logic       mode_on;
  } astc_ctrl_t;

endpackage
`default_nettype wire

// File: verilog/astc_trigger.sv
// Acquisition start trigger controller with Avalon-MM register slave
// How it works
// - Software fire starts exposure only when mode on, software source, and waiting
// - Accepting a software trigger leaves the waiting state at exposure start
// - Waiting state returns by itself once a new trigger can be taken
// - Software fire while not waiting is dropped with no effect
// - Software fire counts only while selector names the acquisition start trigger
// - With a line source, the selected input line is the trigger
// - Rising or falling edge of the line chosen by a setting
// - Configured edge while waiting starts a frame acquisition
// - Edges while not waiting are ignored and start nothing
// - Exactly one frame per accepted trigger
// - Hardware triggering offers timed and trigger-width exposure
// - Timed mode exposes from the edge for the programmed time
// - Edge during running timed exposure is ignored and raises overtrigger while still armed
// - Width mode exposes until the opposite edge, extended until readout ends
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`default_nettype none
module astc_trigger
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [1:0]  external_frame_start_line_i,
  output logic             exposure_active_o,
  output logic             waiting_o,
  output logic             overtrigger_o,
  output logic             internal_rate_enable_o
);

  astc_pkg::astc_ctrl_t    ctrl;
  astc_pkg::astc_state_t   state;
  logic [23:0]             exposure_duration_value;
  logic [23:0]             exp_count;
  logic [23:0]             ro_count;
  logic [7:0]              tick_div;
  logic                    tick;
  logic                    armed;
  logic                    ovr_flag;
  logic [15:0]             frames;
  logic [1:0]              line_meta;
  logic [1:0]              line_sync;
  logic                    line_prev;
  logic                    line_now;
  logic                    active_edge;
  logic                    release_edge;
  logic                    host_fire_command;
  logic                    capture_arm_command;
  logic                    capture_disarm_command;
  logic                    ovr_clear;
  logic                    sw_start;
  logic                    hw_start;
  logic                    hw_ovr;
  logic                    bus_ack;
  logic                    wr_take;
  logic                    rd_take;

  // Address match for a register selected by byte address
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  // One wait cycle per access keeps read data registered
  // Read data load one edge early so they stand where waitrequest is low
  assign wr_take = avs_write_i & bus_ack;
  assign rd_take = avs_read_i & ~bus_ack;

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      bus_ack <= 1'b0;
    else
      bus_ack <= (avs_read_i | avs_write_i) & ~bus_ack;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~bus_ack);
  end

  // Command strobes, one cycle each
  assign host_fire_command      = wr_take & hit(avs_address_i, astc_pkg::ADDR_COMMAND)
                                  & avs_byteenable_i[0] & avs_writedata_i[astc_pkg::CMD_FIRE];
  assign capture_arm_command    = wr_take & hit(avs_address_i, astc_pkg::ADDR_COMMAND)
                                  & avs_byteenable_i[0] & avs_writedata_i[astc_pkg::CMD_ARM];
  assign capture_disarm_command = wr_take & hit(avs_address_i, astc_pkg::ADDR_COMMAND)
                                  & avs_byteenable_i[0] & avs_writedata_i[astc_pkg::CMD_DISARM];
  assign ovr_clear              = wr_take & hit(avs_address_i, astc_pkg::ADDR_COMMAND)
                                  & avs_byteenable_i[0] & avs_writedata_i[astc_pkg::CMD_OVR_CLR];

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      ctrl <= astc_pkg::CTRL_RESET;
    else if (wr_take && hit(avs_address_i, astc_pkg::ADDR_CTRL) && avs_byteenable_i[0])
      ctrl <= avs_writedata_i[6:0];
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      exposure_duration_value <= astc_pkg::EXPOSURE_RESET;
    else if (wr_take && hit(avs_address_i, astc_pkg::ADDR_EXPOSURE))
    begin
      if (avs_byteenable_i[0])
        exposure_duration_value[7:0] <= avs_writedata_i[7:0];
      if (avs_byteenable_i[1])
        exposure_duration_value[15:8] <= avs_writedata_i[15:8];
      if (avs_byteenable_i[2])
        exposure_duration_value[23:16] <= avs_writedata_i[23:16];
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      avs_readdata_o <= 32'h00000000;
    else if (rd_take)
    begin
      if (hit(avs_address_i, astc_pkg::ADDR_CTRL))
        avs_readdata_o <= {25'h0000000, ctrl};
      else if (hit(avs_address_i, astc_pkg::ADDR_EXPOSURE))
        avs_readdata_o <= {8'h00, exposure_duration_value};
      else if (hit(avs_address_i, astc_pkg::ADDR_STATUS))
        avs_readdata_o <= {8'h00, frames, 3'h0, ovr_flag, armed,
                           (ro_count != 24'h000000), state == astc_pkg::ST_EXP_S
                           || state == astc_pkg::ST_HOLD_S,
                           state == astc_pkg::ST_WAIT_S};
      else
        avs_readdata_o <= 32'h00000000;
    end
  end

  // Two flops per line before any logic looks at it
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      line_meta <= 2'h0;
      line_sync <= 2'h0;
    end
    else
    begin
      line_meta <= external_frame_start_line_i;
      line_sync <= line_meta;
    end
  end

  assign line_now = line_sync[ctrl.line_sel];

  // Selecting a new line may fake one edge; the state check limits the harm
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      line_prev <= 1'b0;
    else
      line_prev <= line_now;
  end

  assign active_edge  = ctrl.falling ? (line_prev & ~line_now) : (~line_prev & line_now);
  assign release_edge = ctrl.falling ? (~line_prev & line_now) : (line_prev & ~line_now);

  // Microsecond tick divider
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      tick_div <= 8'h00;
    else if (tick_div == astc_pkg::TICK_LAST)
      tick_div <= 8'h00;
    else
      tick_div <= tick_div + 8'h01;
  end

  assign tick = (tick_div == astc_pkg::TICK_LAST);

  // Start conditions
  assign sw_start = host_fire_command & ctrl.mode_on & ctrl.src_sw & ctrl.sel_start
                    & (state == astc_pkg::ST_WAIT_S);
  assign hw_start = active_edge & ctrl.mode_on & ~ctrl.src_sw
                    & (state == astc_pkg::ST_WAIT_S);
  assign hw_ovr   = active_edge & ctrl.mode_on & ~ctrl.src_sw & armed
                    & (state == astc_pkg::ST_EXP_S) & ~ctrl.width_mode;

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      armed <= 1'b0;
    else if (capture_disarm_command)
      armed <= 1'b0;
    else if (capture_arm_command)
      armed <= 1'b1;
  end

  // Exposure state machine
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      state <= astc_pkg::ST_IDLE_S;
    else
    begin
      case (state)
        astc_pkg::ST_IDLE_S:
          if (armed && ctrl.mode_on)
            state <= astc_pkg::ST_WAIT_S;
        astc_pkg::ST_WAIT_S:
          if (!armed || !ctrl.mode_on)
            state <= astc_pkg::ST_IDLE_S;
          else if (sw_start || hw_start)
            state <= astc_pkg::ST_EXP_S;
        astc_pkg::ST_EXP_S:
          // Software source always runs timed
          if (ctrl.width_mode && !ctrl.src_sw)
          begin
            if (release_edge)
              state <= (ro_count != 24'h000000) ? astc_pkg::ST_HOLD_S
                                                 : astc_pkg::ST_WAIT_S;
          end
          else if (tick && exp_count <= 24'h000001)
            state <= astc_pkg::ST_WAIT_S;
        astc_pkg::ST_HOLD_S:
          if (ro_count == 24'h000000)
            state <= astc_pkg::ST_WAIT_S;
        default:
          state <= astc_pkg::ST_IDLE_S;
      endcase
    end
  end

  // Exposure counter loads at start and counts ticks
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      exp_count <= 24'h000000;
    else if (sw_start || hw_start)
      exp_count <= exposure_duration_value;
    else if (tick && exp_count != 24'h000000)
      exp_count <= exp_count - 24'h000001;
  end

  // Readout of the previous frame begins when its exposure ends
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      ro_count <= 24'h000000;
    else if ((state == astc_pkg::ST_EXP_S || state == astc_pkg::ST_HOLD_S)
             && !exposure_next())
      ro_count <= astc_pkg::READOUT_US;
    else if (tick && ro_count != 24'h000000)
      ro_count <= ro_count - 24'h000001;
  end

  function automatic logic exposure_next();
    exposure_next = 1'b1;
    if (state == astc_pkg::ST_EXP_S && ctrl.width_mode && !ctrl.src_sw)
      exposure_next = ~(release_edge && ro_count == 24'h000000);
    else if (state == astc_pkg::ST_EXP_S)
      exposure_next = ~(tick && exp_count <= 24'h000001);
    else if (state == astc_pkg::ST_HOLD_S)
      exposure_next = (ro_count != 24'h000000);
  endfunction

  // Overtrigger: set wins over clear
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      ovr_flag <= 1'b0;
    else if (hw_ovr)
      ovr_flag <= 1'b1;
    else if (ovr_clear)
      ovr_flag <= 1'b0;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      overtrigger_o <= 1'b0;
    else
      overtrigger_o <= hw_ovr;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      frames <= 16'h0000;
    else if (sw_start || hw_start)
      frames <= frames + 16'h0001;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      exposure_active_o      <= 1'b0;
      waiting_o              <= 1'b0;
      internal_rate_enable_o <= 1'b0;
    end
    else
    begin
      exposure_active_o      <= (state == astc_pkg::ST_EXP_S || state == astc_pkg::ST_HOLD_S);
      waiting_o              <= (state == astc_pkg::ST_WAIT_S);
      // No internal generator here; the enable is passed on only while mode is off
      internal_rate_enable_o <= ctrl.rate_en & ~ctrl.mode_on;
    end
  end

endmodule
`default_nettype wire

// File: verif/astc_trigger_assertions.sv
// Checker: port-level properties of the start trigger block
`default_nettype none
module astc_trigger_chk
(
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        exposure_active_o,
  input wire logic        waiting_o,
  input wire logic        overtrigger_o,
  input wire logic        internal_rate_enable_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic rate_q;
  wire  ctrl_wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                  && avs_address_i == astc_pkg::ADDR_CTRL;
  // Expected rate output, captured when a control write is taken
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      rate_q <= 1'b0;
    else if (ctrl_wr)
      rate_q <= avs_writedata_i[6] & ~avs_writedata_i[0];
  end
  sequence exp_start_s;
    !exposure_active_o ##1 exposure_active_o;
  endsequence
  sequence req_wait_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  bus_answer_a: assert property (req_wait_s |=> !avs_waitrequest_o)
    else $error("waitrequest not released");
  // Waiting may lag the state by a cycle, so one extra cycle is allowed
  start_waiting_a: assert property (exp_start_s |-> $past(waiting_o) || $past(waiting_o, 2))
    else $error("exposure began while not waiting");
  start_leave_a: assert property (exp_start_s |=> !waiting_o)
    else $error("waiting kept after exposure start");
  wait_excl_a: assert property (exposure_active_o && $past(exposure_active_o) |-> !waiting_o)
    else $error("waiting during exposure");
  ovr_expose_a: assert property (overtrigger_o |-> exposure_active_o || $past(exposure_active_o))
    else $error("overtrigger outside exposure");
  ovr_pulse_a: assert property (overtrigger_o |=> !overtrigger_o)
    else $error("overtrigger longer than one cycle");
  ovr_idle_a: assert property (overtrigger_o |-> !waiting_o)
    else $error("overtrigger while waiting");
  rate_follow_a: assert property (ctrl_wr |-> ##2 internal_rate_enable_o == rate_q)
    else $error("rate enable output wrong");
endmodule
bind astc_trigger astc_trigger_chk u_astc_trigger_chk
(
  .mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
  .exposure_active_o(exposure_active_o), .waiting_o(waiting_o),
  .overtrigger_o(overtrigger_o), .internal_rate_enable_o(internal_rate_enable_o)
);
`default_nettype wire

// File: verif/astc_line_src.sv
// External trigger line source model
`default_nettype none
module astc_line_src
(
  input  wire logic        mclk_i,
  input  wire logic [1:0]  fire_i,
  input  wire logic        falling_i,
  input  wire logic [15:0] width_i,
  output logic      [1:0]  line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left_q [2] = '{16'h0, 16'h0};
  // Pulse spacing is left to the bench
  always_ff @(posedge mclk_i)
  begin
    for (int k = 0; k < 2; k++)
      if (fire_i[k])
        left_q[k] <= width_i;
      else if (left_q[k] != 16'h0)
        left_q[k] <= left_q[k] - 16'h1;
  end
  // Idle level opposite to the active edge
  always_comb
  begin
    for (int j = 0; j < 2; j++)
      line_o[j] = falling_i ^ (left_q[j] != 16'h0);
  end
endmodule
`default_nettype wire

// File: verif/astc_trigger_bench.sv
// Self-checking bench for the start trigger block
`default_nettype none
module astc_trigger_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic        waitreq;
  logic [1:0]  lines;
  logic        expo;
  logic        waiting;
  logic        ovr;
  logic        rate_en;
  logic [1:0]  fire = 2'h0;
  logic        falling = 1'b0;
  logic [15:0] width = 16'h14;
  logic [7:0]  seed = 8'h50;
  logic        l;
  logic        f;
  int          n_fail = 0;
  int          total_checks = 0;
  int          len;
  int          nov;
  int          frames = 0;
  int          e;
  astc_trigger u_astc_trigger
  (
    .mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .external_frame_start_line_i(lines), .exposure_active_o(expo), .waiting_o(waiting),
    .overtrigger_o(ovr), .internal_rate_enable_o(rate_en)
  );
  astc_line_src u_astc_line_src
  (
    .mclk_i(mclk_i), .fire_i(fire), .falling_i(falling), .width_i(width), .line_o(lines)
  );
  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Tick phase is unknown at start, so one tick of slack below
  function automatic logic [31:0] ok_len(input int n, input int us);
    return 32'(n >= (us - 1) * astc_pkg::TICK_CYCLES && n <= us * astc_pkg::TICK_CYCLES + 8);
  endfunction
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic timeout(input string name);
    check(name, 32'h0, 32'h1);
    final_report();
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    if (waitreq !== 1'b0)
      timeout("waitrequest");
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, q & m, exp);
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 60000 && waiting !== 1'b1; n++)
      @(posedge mclk_i);
    if (waiting !== 1'b1)
      timeout("waiting");
  endtask
  task automatic pulse(input logic [1:0] m);
    fire <= m;
    @(posedge mclk_i);
    fire <= 2'h0;
  endtask
  // Counts exposure cycles and overtrigger pulses; refire re-hits the line
  task automatic run_frame(input int refire);
    len = 0;
    nov = 0;
    for (int n = 0; n < 40 && expo !== 1'b1; n++)
      @(posedge mclk_i);
    while (expo === 1'b1 && len < 60000)
    begin
      @(posedge mclk_i);
      len++;
      nov += int'(ovr === 1'b1);
      fire <= (len == refire) ? {l, ~l} : 2'h0;
    end
    if (expo === 1'b1)
      timeout("exposure");
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    rdchk("ctrl", astc_pkg::ADDR_CTRL, 32'h7f, 32'h21);
    rdchk("exposure", astc_pkg::ADDR_EXPOSURE, 32'hffffff, 32'hbb8);
    rdchk("status", astc_pkg::ADDR_STATUS, 32'hffffffff, 32'h0);
    bus(1'b1, astc_pkg::ADDR_CTRL, 32'h60);
    repeat (3) @(posedge mclk_i);
    check("rate_enable", rate_en, 32'h1);
    seed = lfsr(seed);
    e = 2 + seed[0];
    bus(1'b1, astc_pkg::ADDR_EXPOSURE, 32'(e));
    bus(1'b1, astc_pkg::ADDR_CTRL, 32'h23);
    bus(1'b1, astc_pkg::ADDR_COMMAND, 32'h1);
    repeat (30) @(posedge mclk_i);
    check("fire_unarmed", expo, 32'h0);
    bus(1'b1, astc_pkg::ADDR_COMMAND, 32'h2);
    wait_ready();
    bus(1'b1, astc_pkg::ADDR_CTRL, 32'h03);
    bus(1'b1, astc_pkg::ADDR_COMMAND, 32'h1);
    repeat (30) @(posedge mclk_i);
    check("fire_other_selector", expo, 32'h0);
    bus(1'b1, astc_pkg::ADDR_CTRL, 32'h23);
    bus(1'b1, astc_pkg::ADDR_COMMAND, 32'h1);
    run_frame(-1);
    check("sw_exposure", ok_len(len, e), 32'h1);
    frames++;
    for (int i = 0; i < 2; i++)
    begin
      seed = lfsr(seed);
      {l, f} = seed[1:0];
      bus(1'b1, astc_pkg::ADDR_CTRL, 32'h23);
      falling <= f;
      repeat (10) @(posedge mclk_i);
      bus(1'b1, astc_pkg::ADDR_CTRL, 32'h21 | 32'(l) << 2 | 32'(f) << 3);
      wait_ready();
      pulse({~l, l});
      repeat (30) @(posedge mclk_i);
      check("other_line", expo, 32'h0);
      pulse({l, ~l});
      run_frame(100);
      frames++;
      check("hw_exposure", ok_len(len, e), 32'h1);
      check("overtrigger", nov, 32'h1);
      rdchk("frames", astc_pkg::ADDR_STATUS, 32'hffff00, frames << 8);
    end
    rdchk("ovr_sticky", astc_pkg::ADDR_STATUS, 32'h10, 32'h10);
    bus(1'b1, astc_pkg::ADDR_COMMAND, 32'h8);
    rdchk("ovr_clear", astc_pkg::ADDR_STATUS, 32'h10, 32'h0);
    bus(1'b1, astc_pkg::ADDR_CTRL, 32'h31 | 32'(l) << 2 | 32'(f) << 3);
    wait_ready();
    width <= 16'h4b0;
    pulse({l, ~l});
    run_frame(-1);
    check("width_exposure", 32'(len >= 19000), 32'h1);
    check("width_no_ovr", nov, 32'h0);
    final_report();
  end
  initial
  begin
    repeat (90000) @(posedge mclk_i);
    timeout("run_time");
  end
endmodule
`default_nettype wire
